// [hw/fmbl_pkg.sv]
// constants and types shared by the flash mode and boot-lock logic
// assumes a 19-bit byte address space of 512K locations
package fmbl_pkg;

  localparam int ADDR_W = 19;
  localparam int ROW_W = 8;
  localparam int COL_W = 11;

  // boot block bounds
  localparam logic [18:0] BOOT16_LO = 19'h7c000;
  localparam logic [18:0] BOOT64_LO = 19'h70000;
  localparam logic [18:0] ARRAY_HI = 19'h7ffff;
  localparam logic [18:0] ARRAY_LO = 19'h00000;

  // identification status byte
  localparam logic [18:0] ID_STATUS_ADDR = 19'h7fff2;
  localparam int ST_LOCK64_BIT = 0;
  localparam int ST_LOCK16_BIT = 1;
  localparam int ST_TBL_BIT = 2;
  localparam int ST_WP_BIT = 3;

  // busy-time status bits
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  // default command bytes and unlock addresses, overridable at the top
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_ID_ENTER = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] CMD_ALT_EXIT = 8'hff;
  localparam logic [7:0] CMD_LOCK16 = 8'h70;
  localparam logic [7:0] CMD_LOCK64 = 8'h40;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

  // start field direction codes on hub bits [1:0]
  localparam logic [1:0] HUB_DIR_READ = 2'h0;
  localparam logic [1:0] HUB_DIR_WRITE = 2'h2;
  localparam logic [1:0] HUB_DIR_MASK_LO = 2'h0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    FMBL_CMD_IDLE,
    FMBL_CMD_UNLOCK1,
    FMBL_CMD_UNLOCK2,
    FMBL_CMD_PROGRAM,
    FMBL_CMD_ERASE
  } fmbl_cmd_t;

  typedef struct packed {
    logic              started;
    logic              mode_hub;
    logic              tbl_n_strap;
    logic              wp_n_strap;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [18:0]       wr_addr;
    logic              oe_n_d;
    logic              we_n_d;
    fmbl_cmd_t         cmd;
    logic              id_mode;
    logic              sw_lock16;
    logic              sw_lock64;
    logic [18:0]       last_addr;
    logic [7:0]        last_data;
    logic              toggle;
    logic [7:0]        dq_out;
    logic              prog_req;
    logic              erase_req;
    logic              refused;
    logic [18:0]       op_addr;
    logic [7:0]        op_data;
    logic              frame_d;
    logic              hub_rd;
    logic              hub_wr;
  } fmbl_state_t;

endpackage

// [hw/fmbl_range_hit.sv]
// address window compare used for the protected regions
// assumes lo and hi are inclusive byte addresses within the array
module fmbl_range_hit #(
  parameter logic [18:0] LO = 19'h00000,
  parameter logic [18:0] HI = 19'h7ffff
) (
  input  wire logic [18:0] addr,
  output logic             hit
);

  // inclusive window
  assign hit = (addr >= LO) && (addr <= HI);

endmodule

// [hw/fmbl_top.sv]
// flash access-mode selection, boot-block lockout and pin protection
// assumes pins are synchronous to core_clk; the array engine sits outside
// and reports busy while a program or erase runs
//
// How it works
// - select pin high programmer, low hub mode
// - row gives A[18:11], column A[10:0]
// - data lines float while output gate high
// - start field bits 0,1 set direction
// - reset low halts, floats data and hub nibble lines
// - after reset, control inputs choose read/standby
// - boot block top 16K or 64K
// - software lockout rejects boot program/erase
// - lock pin low at power-on protects boot
// - guard pin low protects other sectors
// - status byte bits 0,1 show lockouts
// - lock pin overrides software lockout bits
// - lock pin covers whole top 64K
// - status bit 2 shows lock pin low
// - status bit 3 inverts guard pin
// - three-byte or single-byte exit leaves identification
// - busy read inverts bit 7 of last byte
// - busy reads toggle bit 6
module fmbl_top #(
  parameter logic [18:0] UNLOCK_ADDR1     = fmbl_pkg::UNLOCK_ADDR1,
  parameter logic [18:0] UNLOCK_ADDR2     = fmbl_pkg::UNLOCK_ADDR2,
  parameter logic [7:0]  UNLOCK_DATA1     = fmbl_pkg::UNLOCK_DATA1,
  parameter logic [7:0]  UNLOCK_DATA2     = fmbl_pkg::UNLOCK_DATA2,
  parameter logic [7:0]  CMD_ID_ENTER     = fmbl_pkg::CMD_ID_ENTER,
  parameter logic [7:0]  CMD_ID_EXIT      = fmbl_pkg::CMD_ID_EXIT,
  parameter logic [7:0]  CMD_ALT_EXIT     = fmbl_pkg::CMD_ALT_EXIT,
  parameter logic [7:0]  CMD_LOCK16       = fmbl_pkg::CMD_LOCK16,
  parameter logic [7:0]  CMD_LOCK64       = fmbl_pkg::CMD_LOCK64,
  parameter logic [7:0]  CMD_PROGRAM      = fmbl_pkg::CMD_PROGRAM,
  parameter logic [7:0]  CMD_ERASE_SETUP  = fmbl_pkg::CMD_ERASE_SETUP,
  parameter logic [7:0]  CMD_SECTOR_ERASE = fmbl_pkg::CMD_SECTOR_ERASE
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        interface_select,
  input  wire logic        top_block_lock_pin_n,
  input  wire logic        sector_guard_pin_n,
  input  wire logic        row_col_sel,
  input  wire logic [10:0] addr_pins,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_n,
  input  wire logic        hub_cycle_frame,
  input  wire logic [3:0]  hub_nibble_bus_in,
  output logic      [3:0]  hub_nibble_bus_out,
  output logic             hub_nibble_bus_oe_n,
  output logic             hub_read_start,
  output logic             hub_write_start,
  output logic             hub_mode,
  output logic      [18:0] array_addr,
  input  wire logic [7:0]  array_rdata,
  input  wire logic        op_busy,
  output logic             prog_req,
  output logic             erase_req,
  output logic      [18:0] op_addr,
  output logic      [7:0]  op_data,
  output logic             op_refused,
  output logic             id_mode
);

  fmbl_pkg::fmbl_state_t s_r;
  fmbl_pkg::fmbl_state_t s_nxt;

  logic [18:0] cur_addr;
  logic        in_boot16;
  logic        in_boot64;
  logic        in_array;
  logic        in_guarded;
  logic        wr_block;
  logic [7:0]  status_byte;
  logic        we_fall;
  logic        we_rise;
  logic        oe_fall;
  logic        prog_mode;

  // row on the high bits, column on the low bits
  assign cur_addr = {s_r.row, s_r.col};

  fmbl_range_hit #(
    .LO (fmbl_pkg::BOOT16_LO),
    .HI (fmbl_pkg::ARRAY_HI)
  ) u_boot16 (
    .addr (s_r.wr_addr),
    .hit  (in_boot16)
  );

  fmbl_range_hit #(
    .LO (fmbl_pkg::BOOT64_LO),
    .HI (fmbl_pkg::ARRAY_HI)
  ) u_boot64 (
    .addr (s_r.wr_addr),
    .hit  (in_boot64)
  );

  fmbl_range_hit #(
    .LO (fmbl_pkg::ARRAY_LO),
    .HI (fmbl_pkg::ARRAY_HI)
  ) u_array (
    .addr (s_r.wr_addr),
    .hit  (in_array)
  );

  // everything outside the top 64K counts as the guarded sectors
  assign in_guarded = in_array && !in_boot64;

  // protection verdict for the address being written
  always_comb begin
    wr_block = 1'b0;
    if (in_boot64 && !s_r.tbl_n_strap) begin
      wr_block = 1'b1;
    end
    if (in_boot64 && s_r.sw_lock64) begin
      wr_block = 1'b1;
    end
    if (in_boot16 && s_r.sw_lock16) begin
      wr_block = 1'b1;
    end
    if (in_guarded && !s_r.wp_n_strap) begin
      wr_block = 1'b1;
    end
  end

  // identification status byte, upper bits zero
  always_comb begin
    status_byte = fmbl_pkg::BYTE_ZERO;
    status_byte[fmbl_pkg::ST_LOCK64_BIT] = s_r.sw_lock64;
    status_byte[fmbl_pkg::ST_LOCK16_BIT] = s_r.sw_lock16;
    status_byte[fmbl_pkg::ST_TBL_BIT] = !s_r.tbl_n_strap;
    status_byte[fmbl_pkg::ST_WP_BIT] = !s_r.wp_n_strap;
  end

  // strobe edges; strobes only count in programmer mode
  assign prog_mode = s_r.started && !s_r.mode_hub;
  assign we_fall = prog_mode && s_r.we_n_d && !we_n;
  assign we_rise = prog_mode && !s_r.we_n_d && we_n;
  assign oe_fall = prog_mode && s_r.oe_n_d && !oe_n;

  // next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.prog_req = 1'b0;
    s_nxt.erase_req = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.hub_rd = 1'b0;
    s_nxt.hub_wr = 1'b0;
    s_nxt.oe_n_d = oe_n;
    s_nxt.we_n_d = we_n;
    s_nxt.frame_d = hub_cycle_frame;

    // mode and straps taken once, on the first edge after release
    if (!s_r.started) begin
      s_nxt.started = 1'b1;
      s_nxt.mode_hub = !interface_select;
      s_nxt.tbl_n_strap = top_block_lock_pin_n;
      s_nxt.wp_n_strap = sector_guard_pin_n;
    end

    // multiplexed address capture
    if (prog_mode && row_col_sel) begin
      s_nxt.row = addr_pins[fmbl_pkg::ROW_W-1:0];
    end
    if (prog_mode && !row_col_sel) begin
      s_nxt.col = addr_pins;
    end

    // address latched as the write strobe falls
    if (we_fall) begin
      s_nxt.wr_addr = cur_addr;
    end

    // command decode as the write strobe rises; writes refused while busy
    if (we_rise && !op_busy) begin
      case (s_r.cmd)
        fmbl_pkg::FMBL_CMD_IDLE: begin
          if (s_r.wr_addr == UNLOCK_ADDR1 && dq_in == UNLOCK_DATA1) begin
            s_nxt.cmd = fmbl_pkg::FMBL_CMD_UNLOCK1;
          end else if (s_r.id_mode && dq_in == CMD_ALT_EXIT) begin
            s_nxt.id_mode = 1'b0;
          end
        end
        fmbl_pkg::FMBL_CMD_UNLOCK1: begin
          if (s_r.wr_addr == UNLOCK_ADDR2 && dq_in == UNLOCK_DATA2) begin
            s_nxt.cmd = fmbl_pkg::FMBL_CMD_UNLOCK2;
          end else begin
            s_nxt.cmd = fmbl_pkg::FMBL_CMD_IDLE;
          end
        end
        fmbl_pkg::FMBL_CMD_UNLOCK2: begin
          s_nxt.cmd = fmbl_pkg::FMBL_CMD_IDLE;
          if (s_r.wr_addr == UNLOCK_ADDR1) begin
            if (dq_in == CMD_ID_ENTER) begin
              s_nxt.id_mode = 1'b1;
            end else if (dq_in == CMD_ID_EXIT) begin
              s_nxt.id_mode = 1'b0;
            end else if (dq_in == CMD_LOCK16) begin
              s_nxt.sw_lock16 = 1'b1;
            end else if (dq_in == CMD_LOCK64) begin
              s_nxt.sw_lock64 = 1'b1;
            end else if (dq_in == CMD_PROGRAM) begin
              s_nxt.cmd = fmbl_pkg::FMBL_CMD_PROGRAM;
            end else if (dq_in == CMD_ERASE_SETUP) begin
              s_nxt.cmd = fmbl_pkg::FMBL_CMD_ERASE;
            end
          end
        end
        fmbl_pkg::FMBL_CMD_PROGRAM: begin
          s_nxt.cmd = fmbl_pkg::FMBL_CMD_IDLE;
          s_nxt.last_addr = s_r.wr_addr;
          s_nxt.last_data = dq_in;
          s_nxt.op_addr = s_r.wr_addr;
          s_nxt.op_data = dq_in;
          s_nxt.refused = wr_block;
          s_nxt.prog_req = !wr_block;
        end
        fmbl_pkg::FMBL_CMD_ERASE: begin
          s_nxt.cmd = fmbl_pkg::FMBL_CMD_IDLE;
          if (dq_in == CMD_SECTOR_ERASE) begin
            s_nxt.last_addr = s_r.wr_addr;
            s_nxt.last_data = ~fmbl_pkg::BYTE_ZERO; // erased byte reads all ones
            s_nxt.op_addr = s_r.wr_addr;
            s_nxt.op_data = dq_in;
            s_nxt.refused = wr_block;
            s_nxt.erase_req = !wr_block;
          end
        end
        default: begin
          s_nxt.cmd = fmbl_pkg::FMBL_CMD_IDLE;
        end
      endcase
    end

    // toggle bit advances once per read while an operation runs
    if (oe_fall && op_busy) begin
      s_nxt.toggle = !s_r.toggle;
    end

    // read data: status byte, busy status, or array data
    if (prog_mode && !oe_n) begin
      if (s_r.id_mode && cur_addr == fmbl_pkg::ID_STATUS_ADDR) begin
        s_nxt.dq_out = status_byte;
      end else if (op_busy && cur_addr == s_r.last_addr) begin
        s_nxt.dq_out = array_rdata;
        s_nxt.dq_out[fmbl_pkg::POLL_BIT] = !s_r.last_data[fmbl_pkg::POLL_BIT];
        s_nxt.dq_out[fmbl_pkg::TOGGLE_BIT] = s_nxt.toggle;
      end else if (op_busy) begin
        s_nxt.dq_out = array_rdata;
        s_nxt.dq_out[fmbl_pkg::TOGGLE_BIT] = s_nxt.toggle;
      end else begin
        s_nxt.dq_out = array_rdata;
      end
    end

    // start field direction, taken as the frame falls
    if (s_r.started && s_r.mode_hub && s_r.frame_d && !hub_cycle_frame) begin
      s_nxt.hub_rd = hub_nibble_bus_in[1:0] == fmbl_pkg::HUB_DIR_READ;
      s_nxt.hub_wr = hub_nibble_bus_in[1:0] == fmbl_pkg::HUB_DIR_WRITE;
    end
  end

  // single state register; reset clears everything, lockouts included, except the straps and strobe/frame delays, which reset high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.tbl_n_strap <= 1'b1;
      s_r.wp_n_strap <= 1'b1;
      s_r.oe_n_d <= 1'b1;
      s_r.we_n_d <= 1'b1;
      s_r.frame_d <= 1'b1;
      s_r.cmd <= fmbl_pkg::FMBL_CMD_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // drive only while gated on; float in reset and in hub mode
  assign dq_oe_n = !(reset_n && prog_mode && !oe_n && we_n);
  assign dq_out = s_r.dq_out;
  // hub turnaround timing lives elsewhere, so this end never drives
  assign hub_nibble_bus_oe_n = 1'b1;
  assign hub_nibble_bus_out = s_r.dq_out[3:0];
  assign hub_read_start = s_r.hub_rd;
  assign hub_write_start = s_r.hub_wr;
  assign hub_mode = s_r.mode_hub;
  assign array_addr = cur_addr;
  assign prog_req = s_r.prog_req;
  assign erase_req = s_r.erase_req;
  assign op_addr = s_r.op_addr;
  assign op_data = s_r.op_data;
  assign op_refused = s_r.refused;
  assign id_mode = s_r.id_mode;

endmodule

// [tb/fmbl_array_model.sv]
// behavioural array engine standing behind the mode and boot-lock block
// assumes one-cycle request pulses with address and data standing beside
module fmbl_array_model #(
  parameter int BUSY_CYC = 12
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        prog_req,
  input  wire logic        erase_req,
  input  wire logic [18:0] op_addr,
  input  wire logic [7:0]  op_data,
  input  wire logic [18:0] array_addr,
  output logic      [7:0]  array_rdata,
  output logic             op_busy
);
  logic [18:0] last_a;
  logic [7:0]  last_d;
  int          cnt;

  // only the last touched byte is kept, every other cell reads erased
  assign array_rdata = (array_addr == last_a) ? last_d : 8'hff;
  assign op_busy = cnt > 0;

  // busy spans a fixed program or erase time after each request
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      last_a <= '0;
      last_d <= 8'hff;
    end else if (prog_req || erase_req) begin
      cnt <= BUSY_CYC;
      last_a <= op_addr;
      last_d <= prog_req ? op_data : 8'hff;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [tb/fmbl_checker.sv]
// concurrent checks on the ports of the mode and boot-lock block
// assumes core_clk with async active-low reset_n; bound into fmbl_top
module fmbl_checker (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        interface_select,
  input wire logic        top_block_lock_pin_n,
  input wire logic        sector_guard_pin_n,
  input wire logic        row_col_sel,
  input wire logic [10:0] addr_pins,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe_n,
  input wire logic        hub_cycle_frame,
  input wire logic [3:0]  hub_nibble_bus_in,
  input wire logic        hub_nibble_bus_oe_n,
  input wire logic        hub_read_start,
  input wire logic        hub_write_start,
  input wire logic        hub_mode,
  input wire logic [18:0] array_addr,
  input wire logic        op_busy,
  input wire logic        prog_req,
  input wire logic        erase_req,
  input wire logic [18:0] op_addr,
  input wire logic        id_mode
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // data lines only driven for a gated read in programmer mode
  AST_GATE_FLOAT: assert property (oe_n || !we_n || hub_mode |-> dq_oe_n)
    else $error("data lines driven outside a read");
  // first edge after release still shows the reset values
  AST_RESET_CLEAR: assert property ($rose(reset_n) |->
    !id_mode && !hub_mode && !prog_req && !erase_req && dq_oe_n)
    else $error("outputs not quiet coming out of reset");
  AST_MODE_PIN: assert property ($rose(reset_n) |=> hub_mode == !interface_select)
    else $error("mode does not follow select pin");
  // start field low bits pick the direction, answer one cycle later
  AST_HUB_READ: assert property (hub_mode && $fell(hub_cycle_frame) &&
    hub_nibble_bus_in[1:0] == fmbl_pkg::HUB_DIR_READ |=> hub_read_start && !hub_write_start)
    else $error("hub read start missing");
  AST_HUB_WRITE: assert property (hub_mode && $fell(hub_cycle_frame) &&
    hub_nibble_bus_in[1:0] == fmbl_pkg::HUB_DIR_WRITE |-> ##1 hub_write_start)
    else $error("hub write start missing");
  // multiplexed address halves land in their own bit ranges
  AST_ROW_BITS: assert property ($past(reset_n) && !hub_mode && row_col_sel |=>
    array_addr[18:11] == $past(addr_pins[7:0]))
    else $error("row address misplaced");
  AST_COL_BITS: assert property ($past(reset_n) && !hub_mode && !row_col_sel |=>
    array_addr[10:0] == $past(addr_pins))
    else $error("column address misplaced");
  // pins are static after power-on, so their current level is the strap
  AST_STATUS_PINS: assert property (id_mode && !oe_n && we_n && !op_busy &&
    array_addr == fmbl_pkg::ID_STATUS_ADDR |=>
    dq_out[3:2] == ~{$past(sector_guard_pin_n), $past(top_block_lock_pin_n)})
    else $error("status pin bits wrong");
  AST_PIN_GUARD: assert property (prog_req || erase_req |->
    (top_block_lock_pin_n || op_addr < fmbl_pkg::BOOT64_LO) &&
    (sector_guard_pin_n || op_addr >= fmbl_pkg::BOOT64_LO))
    else $error("operation let through a pin guard");
  // this end never turns the hub nibble lines around
  AST_HUB_FLOAT: assert property (hub_nibble_bus_oe_n)
    else $error("hub nibble lines driven");
endmodule

bind fmbl_top fmbl_checker fmbl_checker_inst (.*);

// [tb/tb_top.sv]
// self-checking bench for the flash mode and boot-lock block
// assumes default command bytes and the array model as the engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, reset_n, interface_select, top_block_lock_pin_n;
  logic        sector_guard_pin_n, row_col_sel, oe_n, we_n, hub_cycle_frame;
  logic        op_busy, prog_req, erase_req, op_refused, id_mode, dq_oe_n;
  logic        hub_read_start, hub_write_start, hub_mode, rd_flag;
  logic [10:0] addr_pins;
  logic [7:0]  dq_in, dq_out, array_rdata, op_data, d;
  logic [3:0]  hub_nibble_bus_in;
  logic [18:0] array_addr, op_addr, a;
  logic [63:0] exp_q[$];
  int          bad_count, check_count;

  fmbl_top fmbl_top_inst (.*, .hub_nibble_bus_out(), .hub_nibble_bus_oe_n());
  fmbl_array_model #(.BUSY_CYC(12)) fmbl_array_model_inst (.*);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic note(input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back({m, v});
  endtask

  // an empty queue yields a note that no result can match
  task automatic take(input logic [31:0] v);
    logic [63:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
    chk(v & e[63:32], e[31:0]);
  endtask

  // results are paired with the oldest note as they show up
  always @(posedge core_clk) rd_flag <= reset_n & ~oe_n;
  always @(negedge core_clk) begin
    if (rd_flag) take({24'h400000, dq_out});
    if (prog_req) take({4'h1, 1'b0, op_data, op_addr});
    if (erase_req) take({4'h2, 1'b0, 8'h00, op_addr});
    if (op_refused) take(32'h30000000);
    if (hub_read_start) take(32'h50000000);
    if (hub_write_start) take(32'h60000000);
  end

  // pins change only under reset, never while the part runs
  task automatic boot(input logic s, input logic t, input logic g);
    // let a pulse from the last write reach the watcher before reset wipes it
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b0;
    oe_n <= 1'b0;
    interface_select <= s;
    top_block_lock_pin_n <= t;
    sector_guard_pin_n <= g;
    @(negedge core_clk);
    chk({31'h0, dq_oe_n}, 32'h1);
    @(posedge core_clk);
    oe_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic adr(input logic [18:0] x);
    row_col_sel <= 1'b1;
    addr_pins <= {3'h0, x[18:11]};
    dq_in <= ~dq_in;
    @(posedge core_clk);
    row_col_sel <= 1'b0;
    addr_pins <= x[10:0];
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [18:0] x, input logic [7:0] v);
    adr(x);
    we_n <= 1'b0;
    @(posedge core_clk);
    we_n <= 1'b1;
    dq_in <= v;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [18:0] x, input logic [7:0] v, input logic [7:0] m);
    adr(x);
    oe_n <= 1'b0;
    note({24'h400000, v}, {24'hffffff, m});
    @(posedge core_clk);
    oe_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // busy is registered in the engine, so let it rise before looking
  task automatic idle;
    int i;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 50 && op_busy !== 1'b0; i++) @(posedge core_clk);
    if (i == 50) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    idle();
    wr(fmbl_pkg::UNLOCK_ADDR1, fmbl_pkg::UNLOCK_DATA1);
    wr(fmbl_pkg::UNLOCK_ADDR2, fmbl_pkg::UNLOCK_DATA2);
    wr(fmbl_pkg::UNLOCK_ADDR1, c);
  endtask

  task automatic prog(input logic [18:0] x, input logic [7:0] v, input logic ok);
    cmd(fmbl_pkg::CMD_PROGRAM);
    note(ok ? {4'h1, 1'b0, v, x} : 32'h30000000, '1);
    wr(x, v);
  endtask

  task automatic ers(input logic [18:0] x, input logic ok);
    cmd(fmbl_pkg::CMD_ERASE_SETUP);
    note(ok ? 32'h20000000 : 32'h30000000, ok ? 32'hf0000000 : '1);
    wr(x, fmbl_pkg::CMD_SECTOR_ERASE);
  endtask

  task automatic idc(input logic w);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, id_mode}, {31'h0, w});
    @(posedge core_clk);
  endtask

  // three power-on configurations: lock pin, guard pin, hub mode
  initial begin
    {reset_n, row_col_sel, addr_pins, dq_in, hub_nibble_bus_in} = '0;
    {oe_n, we_n, hub_cycle_frame, interface_select} = '1;
    {top_block_lock_pin_n, sector_guard_pin_n} = 2'b11;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'ha05496a4));
    d = 8'($urandom());
    a = {3'($urandom_range(6)), 16'($urandom())};
    boot(1'b1, 1'b0, 1'b1);
    cmd(fmbl_pkg::CMD_ID_ENTER);
    rd(fmbl_pkg::ID_STATUS_ADDR, 8'h04, 8'hff);
    cmd(fmbl_pkg::CMD_ID_EXIT);
    idc(1'b0);
    prog(19'h70010, d, 1'b0);
    prog(fmbl_pkg::ARRAY_HI, d, 1'b0);
    prog(a, d, 1'b1);
    rd(a, {~d[7], 1'b1, 6'h00}, 8'hc0);
    rd(a, {~d[7], 7'h00}, 8'hc0);
    idle();
    rd(a, d, 8'hff);
    ers(a, 1'b1);
    $display("done: lock pin");
    boot(1'b1, 1'b1, 1'b0);
    prog(a, d, 1'b0);
    ers(a, 1'b0);
    prog(fmbl_pkg::BOOT64_LO, d, 1'b1);
    cmd(fmbl_pkg::CMD_LOCK16);
    cmd(fmbl_pkg::CMD_ID_ENTER);
    rd(fmbl_pkg::ID_STATUS_ADDR, 8'h0a, 8'hff);
    wr(a, fmbl_pkg::CMD_ALT_EXIT);
    idc(1'b0);
    prog(fmbl_pkg::BOOT16_LO, d, 1'b0);
    prog(19'h7bfff, d, 1'b1);
    cmd(fmbl_pkg::CMD_LOCK64);
    cmd(fmbl_pkg::CMD_ID_ENTER);
    rd(fmbl_pkg::ID_STATUS_ADDR, 8'h0b, 8'hff);
    cmd(fmbl_pkg::CMD_ID_EXIT);
    prog(fmbl_pkg::BOOT64_LO, d, 1'b0);
    $display("done: soft lock");
    boot(1'b0, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      hub_nibble_bus_in[3:2] <= 2'($urandom());
      hub_nibble_bus_in[1:0] <= k[0] ? fmbl_pkg::HUB_DIR_WRITE : fmbl_pkg::HUB_DIR_READ;
      hub_cycle_frame <= 1'b0;
      note(k[0] ? 32'h60000000 : 32'h50000000, '1);
      @(posedge core_clk);
      hub_cycle_frame <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    cmd(fmbl_pkg::CMD_PROGRAM);
    wr(a, d);
    repeat (4) @(posedge core_clk);
    chk(exp_q.size(), 32'h0);
    $display("done: hub mode");
    conclude();
  end
endmodule
